/* tb_top.sv */
// Bench of the supervisor with the reference tick shortened to one clock.
// Assumes the checker and the host model are compiled before it.
`timescale 1ns/10ps
`include "wwd_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supplyAboveLockout = 1'b0, supplyAboveMin = 1'b0, senseInWindow = 1'b1;
  logic resetDelayCfgHigh = 1'b1, resetDelayCfgFloat = 1'b0, resetDelayCapTrip = 1'b0;
  logic watchdogTimingCfgHigh = 1'b1, watchdogTimingCfgFloat = 1'b0, watchdogTimingCapTrip = 1'b0;
  logic windowSelect0 = 1'b1, windowSelect1 = 1'b1, kickEn = 1'b0;
  logic [16:0] kickPeriod = 17'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic watchdogKickIn, systemResetOutN, systemResetOeN, watchdogFaultOutN, watchdogFaultOeN;
  logic resetDelayCapCharge, resetDelayCapDischarge, watchdogTimingCapCharge;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int errors = 0;
  int nChecks = 0;
  always #2 clk = ~clk;
  wwd_supervisor #(.TICK_CYCLES(1)) i_dut (.*);
  wwd_host_model i_host (.clk, .kickEn, .kickPeriod, .systemResetOutN, .watchdogKickIn);
  ////////////////////////
  task automatic testDone();
    if (errors == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return systemResetOutN;
      1: return watchdogFaultOutN;
      default: return resetDelayCapCharge;
    endcase
  endfunction
  // Waits up to lim clocks for an output to reach v; hit tells if it should
  task automatic expWait(input string nm, input int s, input logic v, input int lim, input logic hit);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(nm, hit, pick(s) === v);
    if (hit && pick(s) !== v) testDone();
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n == 50) begin
      errors++;
      testDone();
    end
  endtask
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 50) begin
      errors++;
      testDone();
    end
  endtask
  ////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    expWait("lockout rst", 0, 1'b1, 600, 1'b0);
    chk("lockout fault", 1, watchdogFaultOutN);
    axiRd(`WWD_REG_CTRL, rd, rs);
    chk("ctrl reset", 32'h1, rd);
    axiRd(4'h8, rd, rs);
    chk("bad rd resp", `WWD_RESP_SLVERR, rs);
    axiWr(4'hc, 32'h0, rs);
    chk("bad wr resp", `WWD_RESP_SLVERR, rs);
    axiWr(`WWD_REG_STATUS, 32'h1ff, rs);
    chk("ro wr resp", `WWD_RESP_OKAY, rs);
    axiRd(`WWD_REG_STATUS, rd, rs);
    chk("status low", 32'h0, rd & 32'h7f);
    supplyAboveLockout <= 1'b1;
    supplyAboveMin <= 1'b1;
    expWait("hold early", 0, 1'b1, 9990, 1'b0);
    expWait("hold end", 0, 1'b1, 600, 1'b1);
    axiRd(`WWD_REG_STATUS, rd, rs);
    chk("status run", 32'h12, rd & 32'h13);
    chk("wd charge", 0, watchdogTimingCapCharge);
    kickPeriod <= 17'd4999;
    kickEn <= 1'b1;
    expWait("kick ok", 1, 1'b0, 20000, 1'b0);
    kickPeriod <= 17'd999;
    expWait("early kick", 1, 1'b0, 6000, 1'b1);
    chk("fault oe", 0, watchdogFaultOeN);
    kickEn <= 1'b0;
    chk("rst kept", 1, systemResetOutN);
    expWait("fault hold", 1, 1'b1, 9980, 1'b0);
    expWait("fault end", 1, 1'b1, 200, 1'b1);
    expWait("no kick", 1, 1'b0, 11280, 1'b0);
    expWait("late fault", 1, 1'b0, 100, 1'b1);
    senseInWindow <= 1'b0;
    expWait("sense drop", 0, 1'b0, 8, 1'b1);
    chk("rst oe", 0, systemResetOeN);
    expWait("fault off", 1, 1'b1, 3, 1'b1);
    resetDelayCfgHigh <= 1'b0;
    repeat (600) @(posedge clk);
    senseInWindow <= 1'b1;
    expWait("charge on", 2, 1'b1, 10, 1'b1);
    repeat (300) @(posedge clk);
    chk("no release", 0, systemResetOutN);
    resetDelayCapTrip <= 1'b1;
    expWait("charge off", 2, 1'b0, 8, 1'b1);
    chk("discharge", 1, resetDelayCapDischarge);
    expWait("cap offset", 0, 1'b1, 490, 1'b0);
    expWait("cap release", 0, 1'b1, 30, 1'b1);
    resetDelayCapTrip <= 1'b0;
    axiWr(`WWD_REG_CTRL, 32'h0, rs);
    expWait("sw off", 1, 1'b0, 12000, 1'b0);
    axiWr(`WWD_REG_CTRL, 32'h1, rs);
    windowSelect1 <= 1'b0;
    expWait("sel off", 1, 1'b0, 12000, 1'b0);
    testDone();
  end
  initial begin
    #380000;
    errors++;
    testDone();
  end
endmodule
bind wwd_supervisor wwd_supervisor_chk i_chk (.clk, .sys_rst, .supplyAboveLockout, .senseInWindow,
  .systemResetOutN, .watchdogFaultOutN, .resetDelayCapTrip, .resetDelayCapCharge, .resetDelayCapDischarge);

/* wwd_host_model.sv */
// Host model: kicks the watchdog at a set interval while reset is released.
// Assumes the bench sets the interval in clocks and enables kicking.
`timescale 1ns/10ps
module wwd_host_model (
  // Clock
  input wire logic clk,
  // Kick control
  input wire logic kickEn,
  input wire logic [16:0] kickPeriod,
  // Device side
  input wire logic systemResetOutN,
  output logic watchdogKickIn
);
  logic [16:0] cnt = 17'h0;
  initial watchdogKickIn = 1'b1;
  // Falling edge every kickPeriod+1 clocks, low for 4 clocks
  always @(posedge clk) begin
    if (!kickEn || !systemResetOutN) begin
      cnt <= 17'h0;
      watchdogKickIn <= 1'b1;
    end else begin
      cnt <= (cnt >= kickPeriod) ? 17'h0 : cnt + 17'h1;
      watchdogKickIn <= (cnt > 17'h3);
    end
  end
endmodule

/* wwd_params.svh */
// Constants of the window watchdog supervisor: times, table values, register map.
// Assumes the includer counts time in reference ticks of one microsecond.
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH
////////////////////////////////////////////////////////////////////////////////
// Clock and reference tick
`define WWD_CLK_NS 4
`define WWD_TICK_NS 1000
`define WWD_TICK_CYCLES ((`WWD_TICK_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`define WWD_CNT_W 27
////////////////////////////////////////////////////////////////////////////////
// Durations in ticks of one microsecond
`define WWD_DETECT_US 27'd500
`define WWD_SETTLE_US 27'd300
`define WWD_HOLD_FLOAT_US 27'd200000
`define WWD_HOLD_HIGH_US 27'd10000
`define WWD_RST_CAP_OFFSET_US 27'd500
`define WWD_WD_CAP_OFFSET_US 27'd55000
// Fixed windows, pin floating: lower / upper
`define WWD_FL_L00_US 27'd22500
`define WWD_FL_U00_US 27'd55000
`define WWD_FL_L01_US 27'd1880
`define WWD_FL_U01_US 27'd27500
`define WWD_FL_L11_US 27'd800000
`define WWD_FL_U11_US 27'd1600000
// Fixed windows, pin tied to supply: lower / upper
`define WWD_HI_L00_US 27'd8800
`define WWD_HI_U00_US 27'd110000
`define WWD_HI_L01_US 27'd8800
`define WWD_HI_U01_US 27'd195000
`define WWD_HI_L11_US 27'd1880
`define WWD_HI_U11_US 27'd11300
// Window select code that turns the watchdog off
`define WWD_SEL_OFF 2'b10
////////////////////////////////////////////////////////////////////////////////
// Register map
`define WWD_AXI_AW 4
`define WWD_REG_CTRL 4'h0
`define WWD_REG_STATUS 4'h4
`define WWD_CTRL_EN_BIT 0
`define WWD_CTRL_RESET 1'b1
`define WWD_ST_RS_LSB 0
`define WWD_ST_WD_LSB 2
`define WWD_ST_SETTLED_BIT 4
`define WWD_ST_RCFG_LSB 5
`define WWD_ST_WCFG_LSB 7
`define WWD_RESP_OKAY 2'b00
`define WWD_RESP_SLVERR 2'b10
`endif

/* wwd_pkg.sv */
// Types of the window watchdog supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package wwd_pkg;
  typedef enum logic [1:0] {RS_LOW, RS_HOLD, RS_RUN} wwd_rst_state_t;
  typedef enum logic [1:0] {WD_OFF, WD_MEAS, WD_RUN, WD_FAULT} wwd_wd_state_t;
  typedef enum logic [1:0] {CFG_HIGH, CFG_FLOAT, CFG_CAP} wwd_cfg_t;
endpackage

/* wwd_supervisor.sv */
// Supervisor sequencing and window watchdog with an AXI4-Lite register slave.
// Assumes pin inputs are asynchronous levels and the bus is on clk.
//
// How it works
// - Below lockout, reset stays low, fault stays high, kicks are ignored.
// - Between lockout and minimum supply, reset follows the monitored input.
// - After settling above minimum, reset releases inside window, asserts outside.
// - Any reset assertion forces the fault output high.
// - Kick intervals below lower or above upper bound raise a fault.
// - On reset assertion the delay pin is classified within the detection time.
// - Floating delay pin gives 200 ms hold, tied high gives 10 ms.
// - Capacitor mode charges until trip, then discharges and releases reset.
// - Capacitor hold equals charge time plus a fixed 0.5 ms offset.
// - Capacitor hold bounds follow the capacitor; logic adds only the offset.
// - Timing pin picks floating set, tied-high set, or capacitor upper bound.
// - Capacitor upper bound is measured charge time plus 55 ms.
// - Floating timing pin window table; select 10 disables the watchdog.
// - Tied-high timing pin window table; select 10 disables the watchdog.
// - Capacitor mode lower bound is 1/8, 3/4 or 1/2 of upper.
// - While reset is asserted the watchdog is off and kicks are ignored.
// - A missed window drives the fault low for one hold time, reset untouched.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "wwd_params.svh"
module wwd_supervisor
  import wwd_pkg::*;
#(
  parameter int TICK_CYCLES = `WWD_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Supply and monitored input comparators
  input wire logic supplyAboveLockout,
  input wire logic supplyAboveMin,
  input wire logic senseInWindow,
  // Host side
  input wire logic watchdogKickIn,
  output logic systemResetOutN,
  output logic systemResetOeN,
  output logic watchdogFaultOutN,
  output logic watchdogFaultOeN,
  // Reset delay configuration pin
  input wire logic resetDelayCfgHigh,
  input wire logic resetDelayCfgFloat,
  input wire logic resetDelayCapTrip,
  output logic resetDelayCapCharge,
  output logic resetDelayCapDischarge,
  // Watchdog timing configuration pin
  input wire logic watchdogTimingCfgHigh,
  input wire logic watchdogTimingCfgFloat,
  input wire logic watchdogTimingCapTrip,
  output logic watchdogTimingCapCharge,
  // Window selects
  input wire logic windowSelect0,
  input wire logic windowSelect1,
  // AXI4-Lite slave
  input wire logic [`WWD_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`WWD_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int CW = `WWD_CNT_W;

  //////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic wwd_cfg_t classify(input logic high, input logic float);
    if (high) return CFG_HIGH;
    if (float) return CFG_FLOAT;
    return CFG_CAP;
  endfunction

  // Returns {lower, upper} in ticks
  function automatic logic [2*CW-1:0] winBounds(input wwd_cfg_t cfg, input logic [1:0] sel,
                                                input logic [CW-1:0] capUpper);
    logic [CW-1:0] lo;
    logic [CW-1:0] up;
    lo = '0;
    up = capUpper;
    case (cfg)
      CFG_FLOAT: begin
        case (sel)
          2'b00: begin lo = `WWD_FL_L00_US; up = `WWD_FL_U00_US; end
          2'b01: begin lo = `WWD_FL_L01_US; up = `WWD_FL_U01_US; end
          default: begin lo = `WWD_FL_L11_US; up = `WWD_FL_U11_US; end
        endcase
      end
      CFG_HIGH: begin
        case (sel)
          2'b00: begin lo = `WWD_HI_L00_US; up = `WWD_HI_U00_US; end
          2'b01: begin lo = `WWD_HI_L01_US; up = `WWD_HI_U01_US; end
          default: begin lo = `WWD_HI_L11_US; up = `WWD_HI_U11_US; end
        endcase
      end
      default: begin
        case (sel)
          2'b00: lo = capUpper >> 3;
          2'b01: lo = capUpper - (capUpper >> 2);
          default: lo = capUpper >> 1;
        endcase
      end
    endcase
    return {lo, up};
  endfunction

  function automatic logic [CW-1:0] holdTicks(input wwd_cfg_t cfg, input logic [CW-1:0] capHold);
    case (cfg)
      CFG_FLOAT: return `WWD_HOLD_FLOAT_US;
      CFG_HIGH: return `WWD_HOLD_HIGH_US;
      default: return capHold;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and tick
  logic [11:0] syncd;
  logic tick;
  logic lockS, minS, senseS, kickS, rHighS, rFloatS, rTripS, wHighS, wFloatS, wTripS;
  logic [1:0] selS;

  wwd_sync #(.W(12)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({supplyAboveLockout, supplyAboveMin, senseInWindow, watchdogKickIn,
          resetDelayCfgHigh, resetDelayCfgFloat, resetDelayCapTrip,
          watchdogTimingCfgHigh, watchdogTimingCfgFloat, watchdogTimingCapTrip,
          windowSelect0, windowSelect1}),
    .dout(syncd)
  );

  wwd_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  assign {lockS, minS, senseS, kickS, rHighS, rFloatS, rTripS, wHighS, wFloatS, wTripS} = syncd[11:2];
  assign selS = syncd[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Supply, reset sequencing
  wwd_rst_state_t rs_reg, rs_next;
  wwd_cfg_t rCfg_reg, rCfg_next;
  logic [CW-1:0] dCnt_reg, dCnt_next, rCnt_reg, rCnt_next, oCnt_reg, oCnt_next;
  logic [CW-1:0] sCnt_reg, sCnt_next, holdLen_reg, holdLen_next;
  logic cfgDone_reg, cfgDone_next, capPh_reg, capPh_next, settled_reg, settled_next;
  logic kickPrev_reg;
  logic pwrOk;
  logic kickFall;

  assign pwrOk = lockS & senseS;
  assign kickFall = kickPrev_reg & ~kickS;

  always_comb begin
    rs_next = rs_reg;
    rCfg_next = rCfg_reg;
    dCnt_next = dCnt_reg;
    rCnt_next = rCnt_reg;
    oCnt_next = oCnt_reg;
    holdLen_next = holdLen_reg;
    cfgDone_next = cfgDone_reg;
    capPh_next = capPh_reg;
    sCnt_next = minS ? sCnt_reg : '0;
    settled_next = minS & settled_reg;
    if (minS && tick && !settled_reg) begin
      sCnt_next = sCnt_reg + 27'd1;
      settled_next = (sCnt_reg >= `WWD_SETTLE_US - 27'd1);
    end
    case (rs_reg)
      RS_LOW: begin
        if (!cfgDone_reg && tick) begin
          dCnt_next = dCnt_reg + 27'd1;
          if (dCnt_reg >= `WWD_DETECT_US - 27'd1) begin
            rCfg_next = classify(rHighS, rFloatS);
            cfgDone_next = 1'b1;
          end
        end
        if (cfgDone_reg && pwrOk) begin
          rs_next = RS_HOLD;
          rCnt_next = '0;
          oCnt_next = '0;
          capPh_next = 1'b0;
        end
      end
      RS_HOLD: begin
        if (tick) rCnt_next = rCnt_reg + 27'd1;
        if (rCfg_reg == CFG_CAP) begin
          if (!capPh_reg && rTripS) capPh_next = 1'b1;
          if (capPh_reg && tick) oCnt_next = oCnt_reg + 27'd1;
          if (capPh_reg && oCnt_reg >= `WWD_RST_CAP_OFFSET_US) begin
            rs_next = RS_RUN;
            holdLen_next = rCnt_reg;
          end
        end else if (rCnt_reg >= holdTicks(rCfg_reg, holdLen_reg)) begin
          rs_next = RS_RUN;
        end
      end
      RS_RUN: rs_next = RS_RUN;
      default: rs_next = RS_LOW;
    endcase
    if (!pwrOk) begin
      rs_next = RS_LOW;
      if (rs_reg != RS_LOW) begin
        cfgDone_next = 1'b0;
        dCnt_next = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs_reg <= RS_LOW;
      rCfg_reg <= CFG_FLOAT;
      dCnt_reg <= '0;
      rCnt_reg <= '0;
      oCnt_reg <= '0;
      sCnt_reg <= '0;
      holdLen_reg <= '0;
      cfgDone_reg <= 1'b0;
      capPh_reg <= 1'b0;
      settled_reg <= 1'b0;
      kickPrev_reg <= 1'b0;
    end else begin
      rs_reg <= rs_next;
      rCfg_reg <= rCfg_next;
      dCnt_reg <= dCnt_next;
      rCnt_reg <= rCnt_next;
      oCnt_reg <= oCnt_next;
      sCnt_reg <= sCnt_next;
      holdLen_reg <= holdLen_next;
      cfgDone_reg <= cfgDone_next;
      capPh_reg <= capPh_next;
      settled_reg <= settled_next;
      kickPrev_reg <= kickS;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Window watchdog
  wwd_wd_state_t wd_reg, wd_next;
  wwd_cfg_t wCfg_reg, wCfg_next;
  logic [1:0] sel_reg, sel_next;
  logic [CW-1:0] wCnt_reg, wCnt_next, capUp_reg, capUp_next;
  logic first_reg, first_next, measured_reg, measured_next;
  logic ctrlEn_reg;
  logic wdEnable;
  logic [2*CW-1:0] bounds;

  assign wdEnable = (rs_reg == RS_RUN) && (selS != `WWD_SEL_OFF) && ctrlEn_reg;
  assign bounds = winBounds(wCfg_reg, sel_reg, capUp_reg);

  always_comb begin
    wd_next = wd_reg;
    wCfg_next = wCfg_reg;
    sel_next = sel_reg;
    wCnt_next = wCnt_reg;
    capUp_next = capUp_reg;
    first_next = first_reg;
    measured_next = measured_reg;
    if (rs_reg != RS_RUN) begin
      wCfg_next = classify(wHighS, wFloatS);
      sel_next = selS;
      measured_next = 1'b0;
    end
    case (wd_reg)
      WD_OFF: begin
        wCnt_next = '0;
        first_next = 1'b1;
        if (wdEnable) wd_next = (wCfg_reg == CFG_CAP && !measured_reg) ? WD_MEAS : WD_RUN;
      end
      WD_MEAS: begin
        if (tick) wCnt_next = wCnt_reg + 27'd1;
        if (wTripS) begin
          capUp_next = wCnt_reg + `WWD_WD_CAP_OFFSET_US;
          measured_next = 1'b1;
          wCnt_next = '0;
          wd_next = WD_RUN;
        end
      end
      WD_RUN: begin
        if (tick) wCnt_next = wCnt_reg + 27'd1;
        if (kickFall) begin
          wCnt_next = '0;
          first_next = 1'b0;
          if (!first_reg && wCnt_reg < bounds[2*CW-1:CW]) wd_next = WD_FAULT;
        end else if (wCnt_reg >= bounds[CW-1:0]) begin
          wCnt_next = '0;
          wd_next = WD_FAULT;
        end
      end
      WD_FAULT: begin
        if (tick) wCnt_next = wCnt_reg + 27'd1;
        if (wCnt_reg >= holdTicks(rCfg_reg, holdLen_reg)) begin
          wCnt_next = '0;
          first_next = 1'b1;
          wd_next = WD_RUN;
        end
      end
      default: wd_next = WD_OFF;
    endcase
    if (!wdEnable || rs_next != RS_RUN) wd_next = WD_OFF;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_reg <= WD_OFF;
      wCfg_reg <= CFG_FLOAT;
      sel_reg <= 2'h0;
      wCnt_reg <= '0;
      capUp_reg <= '0;
      first_reg <= 1'b1;
      measured_reg <= 1'b0;
    end else begin
      wd_reg <= wd_next;
      wCfg_reg <= wCfg_next;
      sel_reg <= sel_next;
      wCnt_reg <= wCnt_next;
      capUp_reg <= capUp_next;
      first_reg <= first_next;
      measured_reg <= measured_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      systemResetOutN <= 1'b0;
      systemResetOeN <= 1'b0;
      watchdogFaultOutN <= 1'b1;
      watchdogFaultOeN <= 1'b1;
      resetDelayCapCharge <= 1'b0;
      resetDelayCapDischarge <= 1'b1;
      watchdogTimingCapCharge <= 1'b0;
    end else begin
      systemResetOutN <= (rs_next == RS_RUN);
      systemResetOeN <= (rs_next == RS_RUN);
      watchdogFaultOutN <= (wd_next != WD_FAULT);
      watchdogFaultOeN <= (wd_next != WD_FAULT);
      resetDelayCapCharge <= (rs_next == RS_HOLD) && (rCfg_next == CFG_CAP) && !capPh_next;
      resetDelayCapDischarge <= !((rs_next == RS_HOLD) && (rCfg_next == CFG_CAP) && !capPh_next);
      watchdogTimingCapCharge <= (wd_next == WD_MEAS);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [`WWD_AXI_AW-1:0] awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next, rdata_next, status;
  logic wStrb0_reg, wStrb0_next, ctrlEn_next;
  logic bvalid_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;

  always_comb begin
    status = '0;
    status[`WWD_ST_RS_LSB +: 2] = rs_reg;
    status[`WWD_ST_WD_LSB +: 2] = wd_reg;
    status[`WWD_ST_SETTLED_BIT] = settled_reg;
    status[`WWD_ST_RCFG_LSB +: 2] = rCfg_reg;
    status[`WWD_ST_WCFG_LSB +: 2] = wCfg_reg;
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb0_next = wStrb0_reg;
    ctrlEn_next = ctrlEn_reg;
    bvalid_next = s_axi_bvalid && !s_axi_bready;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid && !s_axi_rready;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb0_next = s_axi_wstrb[0];
    end
    if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `WWD_RESP_OKAY;
      if (awAddr_reg == `WWD_REG_CTRL) begin
        if (wStrb0_reg) ctrlEn_next = wData_reg[`WWD_CTRL_EN_BIT];
      end else if (awAddr_reg != `WWD_REG_STATUS) begin
        bresp_next = `WWD_RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `WWD_RESP_OKAY;
      rdata_next = '0;
      case (s_axi_araddr)
        `WWD_REG_CTRL: rdata_next[`WWD_CTRL_EN_BIT] = ctrlEn_reg;
        `WWD_REG_STATUS: rdata_next = status;
        default: rresp_next = `WWD_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb0_reg <= 1'b0;
      ctrlEn_reg <= `WWD_CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= '0;
    end else begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb0_reg <= wStrb0_next;
      ctrlEn_reg <= ctrlEn_next;
      s_axi_awready <= !awHeld_next;
      s_axi_wready <= !wHeld_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
    end
  end
endmodule

/* wwd_supervisor_chk.sv */
// Checker of reset, fault and delay capacitor behaviour of the supervisor.
// Assumes it is bound to wwd_supervisor and sees only its ports.
`timescale 1ns/10ps
module wwd_supervisor_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Supply and sense
  input wire logic supplyAboveLockout,
  input wire logic senseInWindow,
  // Host side outputs
  input wire logic systemResetOutN,
  input wire logic watchdogFaultOutN,
  // Delay capacitor
  input wire logic resetDelayCapTrip,
  input wire logic resetDelayCapCharge,
  input wire logic resetDelayCapDischarge
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////
  a_lockout_rst_low: assert property (!supplyAboveLockout [*5] |-> !systemResetOutN)
    else $error("reset high below lockout");
  a_window_rst_low: assert property (!senseInWindow [*5] |-> !systemResetOutN)
    else $error("reset high outside window");
  a_release_cause: assert property ($rose(systemResetOutN) |-> $past(senseInWindow, 4) && $past(supplyAboveLockout, 4))
    else $error("reset released without valid supply and sense");
  a_rst_clears_fault: assert property (!systemResetOutN [*3] |-> watchdogFaultOutN)
    else $error("fault low while reset low");
  a_fault_keeps_rst: assert property ($fell(watchdogFaultOutN) |-> systemResetOutN)
    else $error("fault raised with reset low");
  a_fault_min_len: assert property ($fell(watchdogFaultOutN) |=> (!watchdogFaultOutN || !systemResetOutN) [*8])
    else $error("fault pulse too short");
  a_charge_holds_rst: assert property (resetDelayCapCharge |-> !systemResetOutN && !resetDelayCapDischarge)
    else $error("charging with reset released or discharge on");
  a_trip_ends_charge: assert property (resetDelayCapTrip [*5] |-> !resetDelayCapCharge)
    else $error("charging past trip");
endmodule

/* wwd_sync.sv */
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from a pin.
`timescale 1ns/10ps
module wwd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;
endmodule

/* wwd_tick.sv */
// Reference tick: one-cycle pulse every CYCLES clocks.
// Assumes CYCLES is between 1 and 65536.
`timescale 1ns/10ps
module wwd_tick #(
  parameter int CYCLES = 250
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Tick pulse
  output logic tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_next;

  always_comb begin
    tick_next = (cnt_reg == 16'(CYCLES - 1));
    cnt_next = tick_next ? 16'h0 : cnt_reg + 16'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 16'h0;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule
